// File: hw/edm_defs.svh
// constants for the energy detection block: offsets, codes, timing
// assumes the includer has a 125 MHz ref_clk
`ifndef EDM_DEFS_SVH
`define EDM_DEFS_SVH

`define EDM_ADDR_W          6
`define EDM_ENERGY_OFFSET   6'h07
`define EDM_ENERGY_RESET    8'hff
`define EDM_ENERGY_MAX      8'h53
`define EDM_CLK_MHZ         125
`define EDM_WIN_LONG_US     128
`define EDM_WIN_SHORT_US    32
`define EDM_WIN_LONG_CYC    (`EDM_WIN_LONG_US * `EDM_CLK_MHZ)
`define EDM_WIN_SHORT_CYC   (`EDM_WIN_SHORT_US * `EDM_CLK_MHZ)
`define EDM_RSSI_PERIOD_US  2
`define EDM_RSSI_PERIOD_CYC (`EDM_RSSI_PERIOD_US * `EDM_CLK_MHZ)
`define EDM_CNT_W           15
`define EDM_ACC_W           16
`define EDM_RSSI_W          5
`define EDM_CCA_MODE_W      2
`define EDM_CCA_OR          2'h0
`define EDM_CCA_ENERGY      2'h1
`define EDM_CCA_CARRIER     2'h2
`define EDM_CCA_AND         2'h3

`endif

// File: hw/edm_pkg.sv
// types for the energy detection block
// assumes edm_defs.svh is available on the include path
package edm_pkg;
    typedef enum logic [1:0] {
        EDM_IDLE,
        EDM_MANUAL,
        EDM_AUTO
    } edm_state_t;
endpackage : edm_pkg

// File: hw/edm_avg.sv
// running average of rssi samples over one measurement window
// assumes samples arrive as one-cycle strobes on ref_clk
`timescale 1ns/10ps
`include "edm_defs.svh"
module edm_avg (
    input  wire logic                     ref_clk,
    input  wire logic                     sys_rst,
    input  wire logic                     clear,
    input  wire logic                     sample_stb,
    input  wire logic [`EDM_RSSI_W-1:0]   rssi,
    input  wire logic                     short_win,
    output logic      [7:0]               level
);
    logic [`EDM_ACC_W-1:0] acc_q;
    logic [`EDM_ACC_W-1:0] lvl_wide;

    // accumulate 3 dB samples; cleared at each window start
    always_ff @(posedge ref_clk) begin
        if (sys_rst || clear) begin
            acc_q <= '0;
        end else if (sample_stb) begin
            acc_q <= acc_q + `EDM_ACC_W'(rssi);
        end
    end

    // long window 64 samples, short 16; times 3 turns 3 dB steps into dB
    always_comb begin
        if (short_win) begin
            lvl_wide = `EDM_ACC_W'((acc_q * 3) >> 4);
        end else begin
            lvl_wide = `EDM_ACC_W'((acc_q * 3) >> 6);
        end
        // clamp so codes above the top value never show
        if (lvl_wide > `EDM_ACC_W'(`EDM_ENERGY_MAX)) begin
            level = `EDM_ENERGY_MAX;
        end else begin
            level = lvl_wide[7:0];
        end
    end
endmodule : edm_avg

// File: hw/edm_top.sv
// energy detection and clear channel assessment decision
// assumes rssi and status inputs come from logic on ref_clk;
// the spi slave presents reg_wr as one-cycle strobes with reg_addr
`timescale 1ns/10ps
`include "edm_defs.svh"
module edm_top
    import edm_pkg::*;
(
    input  wire logic                        ref_clk,
    input  wire logic                        sys_rst,
    input  wire logic                        reg_wr,
    input  wire logic [`EDM_ADDR_W-1:0]      reg_addr,
    input  wire logic [`EDM_RSSI_W-1:0]      rssi,
    input  wire logic                        rx_listen,
    input  wire logic                        rx_busy,
    input  wire logic                        high_rate,
    input  wire logic                        header_sync,
    input  wire logic                        preamble_detect_disable,
    input  wire logic                        frame_complete,
    input  wire logic                        carrier_detect,
    input  wire logic [7:0]                  energy_threshold,
    input  wire logic [`EDM_CCA_MODE_W-1:0]  cca_mode,
    output logic      [7:0]                  energy_level_result,
    output logic                             assess_measure_done,
    output logic                             measuring,
    output logic                             channel_busy
);
    edm_state_t             state_q;
    logic [`EDM_CNT_W-1:0]  win_cnt_q;
    logic [7:0]             rssi_div_q;
    logic                   short_q;
    logic                   frame_locked_q;
    logic                   in_frame_q;
    logic [7:0]             avg_level;
    logic                   sample_stb;
    logic                   win_end;
    logic                   start_manual;
    logic                   start_auto;
    logic                   req_wr;
    logic                   rx_state;
    logic                   above_thr;

    assign req_wr       = reg_wr && (reg_addr == `EDM_ENERGY_OFFSET);
    assign rx_state     = rx_listen || rx_busy;
    // manual request ignored while an automatic window runs
    // a locked frame still runs the window and pulses done, only the store
    // is held back further down
    assign start_manual = req_wr && rx_state
                          && (state_q != EDM_AUTO);
    assign start_auto   = header_sync && !preamble_detect_disable
                          && !in_frame_q;
    // first sample right after start, so the last lands inside the window
    assign sample_stb   = (state_q != EDM_IDLE)
                          && (rssi_div_q == '0);
    assign win_end      = (state_q != EDM_IDLE) && (win_cnt_q == '0);

    // averaging of 5-bit rssi samples over the window
    edm_avg u_avg (
        .ref_clk    (ref_clk),
        .sys_rst    (sys_rst),
        .clear      (start_auto || start_manual),
        .sample_stb (sample_stb),
        .rssi       (rssi),
        .short_win  (short_q),
        .level      (avg_level)
    );

    // window scaling follows the kind of start; manual keeps the full one
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            short_q <= 1'b0;
        end else if (start_auto) begin
            short_q <= high_rate;
        end else if (start_manual) begin
            short_q <= 1'b0;
        end
    end

    // measurement state; automatic start preempts a manual one
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_q <= EDM_IDLE;
        end else if (start_auto) begin
            state_q <= EDM_AUTO;
        end else if (start_manual) begin
            state_q <= EDM_MANUAL;
        end else if (win_end) begin
            state_q <= EDM_IDLE;
        end
    end

    // window down-counter, reloaded at every start
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            win_cnt_q <= '0;
        end else if (start_auto && high_rate) begin
            win_cnt_q <= `EDM_CNT_W'(`EDM_WIN_SHORT_CYC - 1);
        end else if (start_auto || start_manual) begin
            // full window even in high rate modes
            win_cnt_q <= `EDM_CNT_W'(`EDM_WIN_LONG_CYC - 1);
        end else if (state_q != EDM_IDLE && !win_end) begin
            win_cnt_q <= win_cnt_q - `EDM_CNT_W'(1);
        end
    end

    // sample strobe every rssi update period, wrapping divider
    always_ff @(posedge ref_clk) begin
        if (sys_rst || start_auto || start_manual || state_q == EDM_IDLE) begin
            rssi_div_q <= '0;
        end else if (rssi_div_q == 8'(`EDM_RSSI_PERIOD_CYC - 1)) begin
            rssi_div_q <= '0;
        end else begin
            rssi_div_q <= rssi_div_q + 8'h01;
        end
    end

    // frame bookkeeping: one automatic result per frame; a set beats the
    // frame-end clear, but a header on the closing edge is lost when in_frame_q is already set
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            in_frame_q     <= 1'b0;
            frame_locked_q <= 1'b0;
        end else begin
            if (start_auto) begin
                in_frame_q <= 1'b1;
            end else if (frame_complete) begin
                in_frame_q <= 1'b0;
            end
            if (win_end && state_q == EDM_AUTO) begin
                frame_locked_q <= 1'b1;
            end else if (frame_complete) begin
                frame_locked_q <= 1'b0;
            end
        end
    end

    // result register loaded whole at completion, 0xff until first result
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            energy_level_result <= `EDM_ENERGY_RESET;
        end else if (win_end && !(state_q == EDM_MANUAL && frame_locked_q)) begin
            // avg_level clamps to the top code, level is base plus 1 dB steps
            energy_level_result <= avg_level;
        end
    end

    // done pulse for manual ends and for refused out-of-receive requests
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            assess_measure_done <= 1'b0;
        end else begin
            assess_measure_done <= (win_end && state_q == EDM_MANUAL)
                                   || (req_wr && !rx_state);
        end
    end

    // busy flag for the host's status view
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            measuring <= 1'b0;
        end else begin
            measuring <= (state_q != EDM_IDLE) && !win_end;
        end
    end

    // unmeasured 0xff must not count as energy
    assign above_thr = (energy_level_result != `EDM_ENERGY_RESET)
                       && (energy_level_result > energy_threshold);

    // channel assessment decision per mode
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            channel_busy <= 1'b0;
        end else begin
            unique case (cca_mode)
                `EDM_CCA_ENERGY:  channel_busy <= above_thr;
                `EDM_CCA_CARRIER: channel_busy <= carrier_detect;
                `EDM_CCA_OR:  channel_busy <= carrier_detect || above_thr;
                `EDM_CCA_AND: channel_busy <= carrier_detect && above_thr;
            endcase
        end
    end
endmodule : edm_top

// File: tb/edm_top_checker.sv
// port assertions for the energy detector
// assumes a bind onto edm_top, one ref_clk domain
`timescale 1ns/10ps
`include "edm_defs.svh"
module edm_top_checker (
    input wire logic       ref_clk,
    input wire logic       sys_rst,
    input wire logic       reg_wr,
    input wire logic [5:0] reg_addr,
    input wire logic [4:0] rssi,
    input wire logic       rx_listen,
    input wire logic       rx_busy,
    input wire logic       high_rate,
    input wire logic       header_sync,
    input wire logic       preamble_detect_disable,
    input wire logic       frame_complete,
    input wire logic       carrier_detect,
    input wire logic [7:0] energy_threshold,
    input wire logic [1:0] cca_mode,
    input wire logic [7:0] energy_level_result,
    input wire logic       assess_measure_done,
    input wire logic       measuring,
    input wire logic       channel_busy
);
    logic [14:0] since_q;
    logic        above;
    // cycles since the last write to the energy register, saturating
    always_ff @(posedge ref_clk) begin
        if (sys_rst)
            since_q <= 15'h7fff;
        else if (reg_wr && reg_addr == `EDM_ENERGY_OFFSET)
            since_q <= 15'h0001;
        else if (since_q != 15'h7fff)
            since_q <= since_q + 15'h0001;
    end
    // the never-measured code is not above any threshold
    assign above = energy_level_result != 8'hff &&
                   energy_level_result > energy_threshold;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    sequence host_ask;
        reg_wr && reg_addr == `EDM_ENERGY_OFFSET;
    endsequence
    sequence off_air;
        !rx_listen && !rx_busy && !measuring;
    endsequence
    chk_reset_code: assert property (disable iff (1'b0)
        sys_rst |=> energy_level_result == 8'hff) else $error("no reset code");
    chk_result_range: assert property (energy_level_result <= 8'h53 ||
        energy_level_result == 8'hff) else $error("result out of range");
    chk_done_single: assert property (assess_measure_done |=>
        !assess_measure_done) else $error("done longer than one cycle");
    chk_off_air_done: assert property (host_ask ##0 off_air |=>
        assess_measure_done) else $error("no done for off-air request");
    chk_done_cause: assert property (assess_measure_done |->
        since_q == 15'h3e81 || since_q == 15'h0001) else $error("stray done");
    chk_result_atomic: assert property (!$past(sys_rst) &&
        !$stable(energy_level_result) |-> $fell(measuring))
        else $error("result moved outside completion");
    chk_mode_or: assert property (cca_mode == 2'h0 |=>
        channel_busy == $past(carrier_detect | above)) else $error("mode 0");
    chk_mode_energy: assert property (cca_mode == 2'h1 |=>
        channel_busy == $past(above)) else $error("mode 1");
    chk_mode_carrier: assert property (cca_mode == 2'h2 |=>
        channel_busy == $past(carrier_detect)) else $error("mode 2");
    chk_mode_and: assert property (cca_mode == 2'h3 |=>
        channel_busy == $past(carrier_detect & above)) else $error("mode 3");
endmodule : edm_top_checker

// File: tb/edm_host.sv
// host model: register writes into the energy detector
// assumes writes are requested from the bench on ref_clk
`timescale 1ns/10ps
module edm_host (
    input  wire logic       ref_clk,
    output logic            reg_wr,
    output logic [5:0]      reg_addr
);
    initial begin
        reg_wr = 1'b0;
        reg_addr = 6'h00;
    end
    // one-cycle strobe; idle address inverted so stale values never match
    task automatic write(input logic [5:0] a);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
    endtask : write
endmodule : edm_host

// File: tb/testbench.sv
// self-checking bench for the energy detector
// assumes edm_top, edm_host and the checker are compiled
`timescale 1ns/10ps
module testbench;
    logic ref_clk = 0, sys_rst = 1, rx_listen = 0, rx_busy = 0, seen;
    logic high_rate = 0, header_sync = 0, preamble_detect_disable = 0;
    logic frame_complete = 0, carrier_detect = 0, reg_wr;
    logic [4:0] rssi = 5'h00;
    logic [7:0] energy_threshold = 8'h00, energy_level_result;
    logic [1:0] cca_mode = 2'h0;
    logic [5:0] reg_addr;
    logic assess_measure_done, measuring, channel_busy;
    logic [15:0] lf = 16'h6d13; // seed 27923
    int fails = 0, comparisons = 0, n, cyc = 0;
    edm_top dut_u (.*);
    edm_host host_u (.ref_clk, .reg_wr, .reg_addr);
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {1'b0, v[15:1]} ^ (v[0] ? 16'hb400 : 16'h0000);
    endfunction : lfsr
    // three dB rssi steps give one dB level steps, clamped at the top
    function automatic logic [7:0] lvl(input logic [4:0] r);
        return (3 * r > 83) ? 8'h53 : 8'(3 * r);
    endfunction : lvl
    function automatic logic busy(input logic [1:0] m, input logic c,
                                  input logic [7:0] e, t);
        logic a;
        a = e != 8'hff && e > t;
        return m == 2'h0 ? c | a : m == 2'h1 ? a : m == 2'h2 ? c : c & a;
    endfunction : busy
    task automatic chk(input string s, input logic [15:0] e, g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask : chk
    // counts cycles to done or to a result change, noting any done
    task automatic waitc(input logic on_done);
        logic [7:0] old;
        #1;
        old = energy_level_result;
        n = 1;
        seen = assess_measure_done;
        while (n < 20000 && (on_done ? !assess_measure_done
                             : energy_level_result === old)) begin
            @(posedge ref_clk);
            #1;
            n++;
            seen |= assess_measure_done;
        end
    endtask : waitc
    task automatic results;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : results
    initial forever #4 ref_clk = ~ref_clk;
    // hang guard, well above the roughly 36k cycles of the sequence
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            fails++;
            results();
        end
    end
    initial begin
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk("reset result", 8'hff, energy_level_result);
        host_u.write(6'h07);
        waitc(1);
        chk("off-air done", 1, n);
        chk("off-air result", 8'hff, energy_level_result);
        // high rate manual in listening, header blocked meanwhile
        @(posedge ref_clk);
        lf = lfsr(lf);
        rssi <= 5'(lf % 29);
        rx_listen <= 1'b1;
        high_rate <= 1'b1;
        preamble_detect_disable <= 1'b1;
        host_u.write(6'h07);
        fork
            waitc(1);
            begin
                repeat (100) @(posedge ref_clk);
                header_sync <= 1'b1;
                @(posedge ref_clk);
                header_sync <= 1'b0;
                #1;
                chk("window running", 1, measuring);
            end
        join
        chk("manual cycles", 16001, n);
        chk("manual level", lvl(rssi), energy_level_result);
        chk("window closed", 0, measuring);
        // automatic short window at the top of the rssi range
        rssi <= 5'h1c;
        rx_listen <= 1'b0;
        rx_busy <= 1'b1;
        preamble_detect_disable <= 1'b0;
        @(posedge ref_clk);
        header_sync <= 1'b1;
        @(posedge ref_clk);
        header_sync <= 1'b0;
        waitc(0);
        chk("auto cycles", 4001, n);
        chk("auto no done", 0, seen);
        chk("auto level", 8'h53, energy_level_result);
        // manual request after the frame's result: done but no store
        rssi <= 5'h05;
        host_u.write(6'h07);
        waitc(1);
        chk("locked cycles", 16001, n);
        chk("locked result", 8'h53, energy_level_result);
        frame_complete <= 1'b1;
        @(posedge ref_clk);
        frame_complete <= 1'b0;
        repeat (40) begin
            @(posedge ref_clk);
            lf = lfsr(lf);
            cca_mode <= lf[1:0];
            carrier_detect <= lf[2];
            energy_threshold <= lf[3] ? 8'h53 - 8'(lf[4]) : lf[15:8];
            @(posedge ref_clk);
            #1;
            chk("busy", busy(cca_mode, carrier_detect, energy_level_result,
                energy_threshold), channel_busy);
        end
        results();
    end
endmodule : testbench
bind edm_top edm_top_checker chk_u (.*);
